// ### src/lcd_pkg.sv
// Constants for the literal and control instruction decoder.
// Assumes a single core clock and 14-bit instruction words.
//
// Contract
// - Watchdog clear word, one cycle, sets status flags
// - Jump loads 11-bit target, takes two cycles
// - Immediate OR into accumulator, updates zero flag
// - Immediate load into accumulator, flags untouched
// - Interrupt return word takes two cycles
// - Return with literal loads accumulator, two cycles
// - Plain return takes two cycles, no flags
// - Standby entry, one cycle, updates status flags
// - Literal minus accumulator updates carry, half, zero
// - Immediate XOR into accumulator, updates zero flag
// - Self-modifying I/O operand comes from pins
// - Writing timer0_count clears assigned prescaler
// - PC change takes two cycles, second is no-op
package lcd_pkg;

    // ------------------------------------------------------------
    // Fixed encodings
    // ------------------------------------------------------------
    localparam logic [13:0] WDT_CLR_WORD  = 14'h0064;
    localparam logic [13:0] STANDBY_WORD  = 14'h0063;
    localparam logic [13:0] IRET_WORD     = 14'h0009;
    localparam logic [13:0] RET_WORD      = 14'h0008;

    // Masked prefixes on bits 13:8 (OR, XOR), 13:9 (subtract), 13:10 (load, return with literal) or 13:11 (jump)
    localparam logic [2:0]  JUMP_PFX      = 3'h5;
    localparam logic [5:0]  OR_PFX        = 6'h38;
    localparam logic [5:0]  XOR_PFX       = 6'h3A;
    localparam logic [3:0]  LOAD_PFX      = 4'hC;
    localparam logic [3:0]  RETLIT_PFX    = 4'hD;
    localparam logic [4:0]  SUB_PFX       = 5'h1E;

    // Reset values
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [10:0] PC_RST        = 11'h000;
    localparam logic        TO_RST        = 1'b1;
    localparam logic        PD_RST        = 1'b1;

    // Cycle counts
    localparam logic [1:0]  CYC_ONE       = 2'h1;
    localparam logic [1:0]  CYC_TWO       = 2'h2;

    typedef enum logic [3:0] {
        OP_NONE    = 4'h0,
        OP_WDT_CLR = 4'h1,
        OP_JUMP    = 4'h2,
        OP_OR      = 4'h3,
        OP_LOAD    = 4'h4,
        OP_IRET    = 4'h5,
        OP_RETLIT  = 4'h6,
        OP_RET     = 4'h7,
        OP_STANDBY = 4'h8,
        OP_SUB     = 4'h9,
        OP_XOR     = 4'hA
    } lcd_op_t;

    typedef enum logic [0:0] {
        ST_EXEC  = 1'h0,
        ST_FLUSH = 1'h1
    } lcd_state_t;

endpackage : lcd_pkg

// ### src/lcd_decode.sv
// Combinational classifier of one 14-bit instruction word.
// Assumes the word is stable from the fetch unit for the cycle.
`timescale 1ns/1ps
module lcd_decode (
    input  wire logic [13:0]      instr,
    output lcd_pkg::lcd_op_t      op
);
    // ------------------------------------------------------------
    // Masked compare; don't-care bits are simply not looked at
    // ------------------------------------------------------------
    always_comb begin
        op = lcd_pkg::OP_NONE;
        if (instr == lcd_pkg::WDT_CLR_WORD) begin
            op = lcd_pkg::OP_WDT_CLR;
        end else if (instr == lcd_pkg::STANDBY_WORD) begin
            op = lcd_pkg::OP_STANDBY;
        end else if (instr == lcd_pkg::IRET_WORD) begin
            op = lcd_pkg::OP_IRET;
        end else if (instr == lcd_pkg::RET_WORD) begin
            op = lcd_pkg::OP_RET;
        end else if (instr[13:11] == lcd_pkg::JUMP_PFX) begin
            op = lcd_pkg::OP_JUMP;
        end else if (instr[13:8] == lcd_pkg::OR_PFX) begin
            op = lcd_pkg::OP_OR;
        end else if (instr[13:8] == lcd_pkg::XOR_PFX) begin
            op = lcd_pkg::OP_XOR;
        end else if (instr[13:10] == lcd_pkg::LOAD_PFX) begin
            op = lcd_pkg::OP_LOAD;
        end else if (instr[13:10] == lcd_pkg::RETLIT_PFX) begin
            op = lcd_pkg::OP_RETLIT;
        end else if (instr[13:9] == lcd_pkg::SUB_PFX) begin
            op = lcd_pkg::OP_SUB;
        end
    end

endmodule : lcd_decode

// ### src/lcd_core.sv
// Execute stage for the literal and control instruction group.
// Assumes the fetch unit presents instr with instr_valid, honours
// flush_ff by discarding the following word, and supplies the
// return address from its own stack.
`timescale 1ns/1ps
module lcd_core (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [13:0]  instr,
    input  wire logic         instr_valid,
    input  wire logic [10:0]  stack_top,
    input  wire logic         io_self_mod,
    input  wire logic [7:0]   io_pins,
    input  wire logic [7:0]   io_latch,
    input  wire logic         timer0_count_write,
    input  wire logic         psa_to_timer0_count,
    output logic      [7:0]   acc_ff,
    output logic              zero_ff,
    output logic              carry_ff,
    output logic              half_ff,
    output logic              timeout_flag_ff,
    output logic              powerdown_flag_ff,
    output logic              wdt_clear_ff,
    output logic              standby_ff,
    output logic              pc_load_ff,
    output logic      [10:0]  pc_target_ff,
    output logic              pop_ff,
    output logic              gie_set_ff,
    output logic              flush_ff,
    output logic      [7:0]   io_operand_ff,
    output logic              presc_clear_ff
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        lcd_pkg::lcd_state_t st;
        logic [7:0]  acc;
        logic        z;
        logic        c;
        logic        dc;
        logic        to;
        logic        pd;
        logic        wdt;
        logic        sby;
        logic        pcl;
        logic [10:0] pct;
        logic        pop;
        logic        gie;
        logic        flush;
        logic [7:0]  ioop;
        logic        pclr;
    } lcd_state_s_t;

    lcd_state_s_t     cur_ff;
    lcd_state_s_t     nxt_cur;
    lcd_pkg::lcd_op_t op;
    logic [8:0]       diff;
    logic [4:0]       hdiff;
    logic             exec;

    lcd_decode u_dec (
        .instr (instr),
        .op    (op)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Second cycle of a PC change swallows the fetched word
    assign exec  = instr_valid && (cur_ff.st == lcd_pkg::ST_EXEC);
    assign diff  = {1'b0, instr[7:0]} - {1'b0, cur_ff.acc};
    assign hdiff = {1'b0, instr[3:0]} - {1'b0, cur_ff.acc[3:0]};

    always_comb begin
        nxt_cur       = cur_ff;
        nxt_cur.wdt   = 1'b0;
        nxt_cur.pcl   = 1'b0;
        nxt_cur.pop   = 1'b0;
        nxt_cur.gie   = 1'b0;
        nxt_cur.flush = 1'b0;
        nxt_cur.st    = lcd_pkg::ST_EXEC;
        // Pins, not latch, feed a self-referencing I/O update
        nxt_cur.ioop  = io_self_mod ? io_pins : io_latch;
        // Any timer write wipes the prescaler only when it is owned
        nxt_cur.pclr  = timer0_count_write && psa_to_timer0_count;
        if (exec) begin
            case (op)
                lcd_pkg::OP_WDT_CLR: begin
                    nxt_cur.wdt = 1'b1;
                    nxt_cur.to  = 1'b1;
                    nxt_cur.pd  = 1'b1;
                    nxt_cur.sby = 1'b0;
                end
                lcd_pkg::OP_STANDBY: begin
                    nxt_cur.wdt = 1'b1;
                    nxt_cur.to  = 1'b1;
                    nxt_cur.pd  = 1'b0;
                    nxt_cur.sby = 1'b1;
                end
                lcd_pkg::OP_JUMP: begin
                    nxt_cur.pcl   = 1'b1;
                    nxt_cur.pct   = instr[10:0];
                    nxt_cur.st    = lcd_pkg::ST_FLUSH;
                    nxt_cur.flush = 1'b1;
                end
                lcd_pkg::OP_IRET: begin
                    nxt_cur.pcl   = 1'b1;
                    nxt_cur.pct   = stack_top;
                    nxt_cur.pop   = 1'b1;
                    nxt_cur.gie   = 1'b1;
                    nxt_cur.st    = lcd_pkg::ST_FLUSH;
                    nxt_cur.flush = 1'b1;
                end
                lcd_pkg::OP_RET: begin
                    nxt_cur.pcl   = 1'b1;
                    nxt_cur.pct   = stack_top;
                    nxt_cur.pop   = 1'b1;
                    nxt_cur.st    = lcd_pkg::ST_FLUSH;
                    nxt_cur.flush = 1'b1;
                end
                lcd_pkg::OP_RETLIT: begin
                    nxt_cur.acc   = instr[7:0];
                    nxt_cur.pcl   = 1'b1;
                    nxt_cur.pct   = stack_top;
                    nxt_cur.pop   = 1'b1;
                    nxt_cur.st    = lcd_pkg::ST_FLUSH;
                    nxt_cur.flush = 1'b1;
                end
                lcd_pkg::OP_OR: begin
                    nxt_cur.acc = cur_ff.acc | instr[7:0];
                    nxt_cur.z   = ((cur_ff.acc | instr[7:0]) == 8'h00);
                end
                lcd_pkg::OP_XOR: begin
                    nxt_cur.acc = cur_ff.acc ^ instr[7:0];
                    nxt_cur.z   = ((cur_ff.acc ^ instr[7:0]) == 8'h00);
                end
                lcd_pkg::OP_LOAD: begin
                    nxt_cur.acc = instr[7:0];
                end
                lcd_pkg::OP_SUB: begin
                    // Carry and half carry are active-high "no borrow"
                    nxt_cur.acc = diff[7:0];
                    nxt_cur.c   = ~diff[8];
                    nxt_cur.dc  = ~hdiff[4];
                    nxt_cur.z   = (diff[7:0] == 8'h00);
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff      <= '0;
            cur_ff.st   <= lcd_pkg::ST_EXEC;
            cur_ff.acc  <= lcd_pkg::ACC_RST;
            cur_ff.pct  <= lcd_pkg::PC_RST;
            cur_ff.to   <= lcd_pkg::TO_RST;
            cur_ff.pd   <= lcd_pkg::PD_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs come straight from the state register
    assign acc_ff            = cur_ff.acc;
    assign zero_ff           = cur_ff.z;
    assign carry_ff          = cur_ff.c;
    assign half_ff           = cur_ff.dc;
    assign timeout_flag_ff   = cur_ff.to;
    assign powerdown_flag_ff = cur_ff.pd;
    assign wdt_clear_ff      = cur_ff.wdt;
    assign standby_ff        = cur_ff.sby;
    assign pc_load_ff        = cur_ff.pcl;
    assign pc_target_ff      = cur_ff.pct;
    assign pop_ff            = cur_ff.pop;
    assign gie_set_ff        = cur_ff.gie;
    assign flush_ff          = cur_ff.flush;
    assign io_operand_ff     = cur_ff.ioop;
    assign presc_clear_ff    = cur_ff.pclr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_wdt_clear_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_WDT_CLR |=> wdt_clear_ff && timeout_flag_ff
            && powerdown_flag_ff)
        else $error("watchdog clear did not set flags");
    a_jump_target: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_JUMP |=> pc_load_ff && pc_target_ff == $past(instr[10:0]))
        else $error("jump target wrong");
    a_or_result: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_OR |=>
            acc_ff == ($past(acc_ff) | $past(instr[7:0])) && zero_ff == (acc_ff == 8'h00))
        else $error("or result wrong");
    a_load_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_LOAD |=>
            acc_ff == $past(instr[7:0]) && $stable(zero_ff) && $stable(carry_ff))
        else $error("load changed flags");
    a_retlit_acc: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_RETLIT |=> acc_ff == $past(instr[7:0]) && pop_ff)
        else $error("return with literal wrong");
    a_ret_two_cyc: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && (op == lcd_pkg::OP_RET || op == lcd_pkg::OP_IRET) |=>
            flush_ff ##1 !flush_ff)
        else $error("return not two cycles");
    a_standby_pd: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_STANDBY |=> !powerdown_flag_ff && timeout_flag_ff
            && standby_ff)
        else $error("standby flags wrong");
    a_sub_result: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_SUB |=>
            acc_ff == 8'($past(instr[7:0]) - $past(acc_ff))
            && carry_ff == ($past(instr[7:0]) >= $past(acc_ff)))
        else $error("subtract result wrong");
    a_xor_result: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_XOR |=> acc_ff == ($past(acc_ff) ^ $past(instr[7:0])))
        else $error("xor result wrong");
    a_io_operand: assert property (@(posedge sys_clk) disable iff (!resetn)
        io_self_mod |=> io_operand_ff == $past(io_pins))
        else $error("self io operand not from pins");
    a_presc_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        timer0_count_write && psa_to_timer0_count |=> presc_clear_ff)
        else $error("prescaler not cleared");
    a_iret_gie: assert property (@(posedge sys_clk) disable iff (!resetn)
        exec && op == lcd_pkg::OP_IRET |=> gie_set_ff && pc_target_ff == $past(stack_top))
        else $error("interrupt return wrong");
    a_load_dontcare: assert property (@(posedge sys_clk) disable iff (!resetn)
        instr[13:10] == lcd_pkg::LOAD_PFX |-> op == lcd_pkg::OP_LOAD)
        else $error("load dont-care decode");

    c_jump:    cover property (@(posedge sys_clk) exec && op == lcd_pkg::OP_JUMP);
    c_sub:     cover property (@(posedge sys_clk) exec && op == lcd_pkg::OP_SUB);
    c_standby: cover property (@(posedge sys_clk) exec && op == lcd_pkg::OP_STANDBY);
    c_retlit:  cover property (@(posedge sys_clk) exec && op == lcd_pkg::OP_RETLIT);

endmodule : lcd_core

// ### testbench/test_literal_control_op_decoder.sv
// Self-checking bench for the literal and control instruction core.
// Assumes lcd_core and lcd_pkg are compiled first; drives all inputs itself.
`timescale 1ns/1ps
module test_literal_control_op_decoder;

    `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
        $display("[ERR] %0t ns: got %h expected %h", $time, (g), (e)); end end

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] w;
        logic [7:0]  acc;
        logic        z;
        logic        c;
        logic        h;
    } lcd_row_t;

    logic        sys_clk;
    logic        resetn;
    logic [13:0] instr;
    logic        instr_valid;
    logic [10:0] stack_top;
    logic        io_self_mod;
    logic [7:0]  io_pins;
    logic [7:0]  io_latch;
    logic        timer0_count_write;
    logic        psa_to_timer0_count;
    logic [7:0]  acc_ff;
    logic        zero_ff, carry_ff, half_ff, timeout_flag_ff, powerdown_flag_ff;
    logic        wdt_clear_ff, standby_ff, pc_load_ff, pop_ff, gie_set_ff, flush_ff;
    logic [10:0] pc_target_ff;
    logic [7:0]  io_operand_ff;
    logic        presc_clear_ff;
    lcd_row_t    rows [9];
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    lcd_core uut (.sys_clk(sys_clk), .resetn(resetn), .instr(instr),
        .instr_valid(instr_valid), .stack_top(stack_top), .io_self_mod(io_self_mod),
        .io_pins(io_pins), .io_latch(io_latch), .timer0_count_write(timer0_count_write),
        .psa_to_timer0_count(psa_to_timer0_count), .acc_ff(acc_ff), .zero_ff(zero_ff),
        .carry_ff(carry_ff), .half_ff(half_ff), .timeout_flag_ff(timeout_flag_ff),
        .powerdown_flag_ff(powerdown_flag_ff), .wdt_clear_ff(wdt_clear_ff),
        .standby_ff(standby_ff), .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
        .pop_ff(pop_ff), .gie_set_ff(gie_set_ff), .flush_ff(flush_ff),
        .io_operand_ff(io_operand_ff), .presc_clear_ff(presc_clear_ff));

    // ------------------------------------------------------------
    // Clock, watchdog on the run, closing report
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // About 30 cycles of tests; the ceiling leaves ample margin for a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 500) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Present one word at the falling edge; returns after the taking edge has landed
    task automatic exec(input logic [13:0] w, input logic v);
        instr = w;
        instr_valid = v;
        @(negedge sys_clk);
    endtask : exec

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0; instr = 14'h0000; instr_valid = 1'b0; stack_top = 11'h000;
        io_self_mod = 1'b0; io_pins = 8'h00; io_latch = 8'h00;
        timer0_count_write = 1'b0; psa_to_timer0_count = 1'b0;
        // Rows run back to back, so each expectation builds on the one before
        rows = '{'{14'h333C, 8'h3C, 1'b0, 1'b0, 1'b0},  // load, dont-care bits set
                 '{14'h38C3, 8'hFF, 1'b0, 1'b0, 1'b0},
                 '{14'h3AFF, 8'h00, 1'b1, 1'b0, 1'b0},
                 '{14'h3000, 8'h00, 1'b1, 1'b0, 1'b0},  // load keeps zero set
                 '{14'h3805, 8'h05, 1'b0, 1'b0, 1'b0},
                 '{14'h3D05, 8'h00, 1'b1, 1'b1, 1'b1},  // subtract to zero
                 '{14'h3C10, 8'h10, 1'b0, 1'b1, 1'b1},
                 '{14'h3C0F, 8'hFF, 1'b0, 1'b0, 1'b1},  // borrow, no nibble borrow
                 '{14'h3A0F, 8'hF0, 1'b0, 1'b0, 1'b1}};
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(acc_ff, 8'h00)
        `CHK({timeout_flag_ff, powerdown_flag_ff, zero_ff}, 3'h6)
        resetn = 1'b1;
        exec(14'h0000, 1'b0);
        `CHK({pc_load_ff, flush_ff, pop_ff, wdt_clear_ff}, 4'h0)
        `CHK(pc_target_ff, 11'h000)
        $display("reset test done");

        // Literal operations from the table
        for (int i = 0; i < 9; i++) begin
            exec(rows[i].w, 1'b1);
            `CHK(acc_ff, rows[i].acc)
            `CHK({zero_ff, carry_ff, half_ff}, {rows[i].z, rows[i].c, rows[i].h})
            `CHK({pc_load_ff, flush_ff}, 2'h0)
        end
        exec(14'h3011, 1'b0);
        `CHK(acc_ff, 8'hF0)
        $display("literal table test done");

        // Jump, then a word in the swallowed slot that must not execute
        exec(14'h2DA3, 1'b1);
        `CHK({pc_load_ff, flush_ff}, 2'h3)
        `CHK(pc_target_ff, 11'h5A3)
        exec(14'h3077, 1'b1);
        `CHK(acc_ff, 8'hF0)
        `CHK({pc_load_ff, flush_ff}, 2'h0)
        $display("jump test done");

        // Return variants, each followed by its swallowed slot
        stack_top = 11'h123;
        exec(14'h3542, 1'b1);
        `CHK({pop_ff, flush_ff, gie_set_ff}, 3'h6)
        `CHK(acc_ff, 8'h42)
        `CHK(pc_target_ff, 11'h123)
        exec(14'h3099, 1'b1);
        `CHK({acc_ff, pop_ff, flush_ff}, {8'h42, 2'h0})
        exec(14'h0008, 1'b1);
        `CHK({pop_ff, flush_ff, gie_set_ff}, 3'h6)
        `CHK({zero_ff, carry_ff, half_ff}, 3'h1)
        exec(14'h3055, 1'b1);
        `CHK(acc_ff, 8'h42)
        stack_top = 11'h2B4;
        exec(14'h0009, 1'b1);
        `CHK({pop_ff, flush_ff, gie_set_ff}, 3'h7)
        `CHK(pc_target_ff, 11'h2B4)
        exec(14'h0000, 1'b1);
        `CHK({pop_ff, flush_ff, gie_set_ff}, 3'h0)
        $display("return test done");

        // Standby entry, then watchdog clear wakes the status back up
        exec(14'h0063, 1'b1);
        `CHK({wdt_clear_ff, standby_ff, flush_ff}, 3'h6)
        `CHK({timeout_flag_ff, powerdown_flag_ff}, 2'h2)
        exec(14'h0064, 1'b1);
        `CHK({wdt_clear_ff, standby_ff, flush_ff}, 3'h4)
        `CHK({timeout_flag_ff, powerdown_flag_ff}, 2'h3)
        `CHK(acc_ff, 8'h42)
        $display("standby test done");

        // I/O operand source and prescaler clear
        io_pins = 8'hA5; io_latch = 8'h5A; io_self_mod = 1'b1;
        exec(14'h0000, 1'b1);
        `CHK(io_operand_ff, 8'hA5)
        io_self_mod = 1'b0; timer0_count_write = 1'b1; psa_to_timer0_count = 1'b1;
        exec(14'h0000, 1'b1);
        `CHK(io_operand_ff, 8'h5A)
        `CHK(presc_clear_ff, 1'b1)
        psa_to_timer0_count = 1'b0;
        exec(14'h0000, 1'b1);
        `CHK(presc_clear_ff, 1'b0)
        timer0_count_write = 1'b0;
        exec(14'h0000, 1'b0);
        $display("io and prescaler test done");

        // Mid-run reset must drop the accumulator and flags back to idle values
        resetn = 1'b0;
        @(negedge sys_clk);
        `CHK({acc_ff, standby_ff, timeout_flag_ff, powerdown_flag_ff}, {8'h00, 3'h3})
        `CHK({zero_ff, carry_ff, half_ff, presc_clear_ff}, 4'h0)
        resetn = 1'b1;
        exec(14'h3C07, 1'b1);
        `CHK({acc_ff, carry_ff, half_ff}, {8'h07, 2'h3})
        $display("mid-run reset test done");
        report_and_stop();
    end

endmodule : test_literal_control_op_decoder
